// ==== verilog/tif_pkg.sv ====
// Purpose: shared constants and types of the thermocouple word formatter
// Assumes: one 40 MHz clock, APB register access
// Notes:   byte offsets, all registers one aligned 32-bit word
package tif_pkg;
    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_FLAG = 8'h20;
    localparam logic [7:0] OFS_CJ   = 8'h24;
    localparam logic [7:0] OFS_GCFG = 8'h28;
    localparam logic [7:0] OFS_IST  = 8'h2c;
    localparam logic [7:0] OFS_IMSK = 8'h30;
    localparam logic [7:0] OFS_CCFG = 8'h40;
    localparam logic [7:0] OFS_LIM  = 8'h60;
    // ------------------------------------------------------------
    // fields and encodings
    // ------------------------------------------------------------
    localparam int         GCFG_FAHR = 0;
    localparam int         GCFG_TENTH = 1;
    localparam int         CCFG_OCD = 3;
    localparam logic [2:0] TY_MV = 3'h0;
    localparam logic [2:0] TY_B  = 3'h7;
    localparam logic [15:0] W_OVER  = 16'h7fff;
    localparam logic [15:0] W_UNDER = 16'h8001;
    localparam logic [15:0] W_OPEN  = 16'hffff;
    // 2.4 percent margin as a ratio
    localparam logic signed [23:0] PCT_NUM = 24'sd24;
    localparam logic signed [23:0] PCT_DEN = 24'sd1000;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [1:0]  RST_GCFG = 2'h2;
    localparam logic [3:0]  RST_CCFG = 4'h8;
    localparam logic [31:0] RST_LIM  = 32'h8000_7fff;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        vld;
        logic [2:0]  ch;
        logic        open;
        logic [15:0] val;
    } tif_smp_t;
    typedef struct packed {
        logic        vld;
        logic [15:0] val;
    } tif_cj_t;
    typedef struct packed {
        logic [7:0][15:0] data;
        logic [7:0]       warn;
        logic [7:0]       oor;
        logic [15:0]      cj;
        logic [1:0]       gcfg;
        logic [7:0][3:0]  ccfg;
        logic [7:0][31:0] lim;
        logic [15:0]      ist;
        logic [15:0]      imsk;
        logic [31:0]      prdata;
        logic             pready;
        logic             pslverr;
        logic             irq;
    } tif_st_t;
endpackage

// ==== verilog/tif_formatter.sv ====
// Purpose: formats eight thermocouple/millivolt readings into input words
// Assumes: samples in signed tenths of deg C (or raw mV code), same clock
// Notes:   zero-wait APB slave; unmapped or misaligned address gives pslverr
//
// Summary of operation
// - ten words: eight readings, one flag word, one internal temperature
// - warning flag when a thermocouple input is beyond the channel rated value
// - out-of-range when a thermocouple is beyond rated by 2.4 percent or wire broken
// - out-of-range clears warning; both never set together
// - output in 0.1 or 1 degree, Celsius or Fahrenheit
// - tenth resolution reports integer tenths, decimal point implied
// - cold junction word uses same units as thermocouple outputs
// - readings are two's complement except the type B case
// - open thermocouple clears warning and sets out-of-range
// - over-range word forced 7FFF, under-range word forced 8001
// - open detect always on for thermocouples, optional for millivolt
// - millivolt with detect on: out-of-range on open or raw FFFF
// - type B in tenth Fahrenheit is unsigned for high readings
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module tif_formatter
    import tif_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    input  wire tif_smp_t    i_smp,
    input  wire tif_cj_t     i_cj,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic signed [23:0] tif_conv(
        input logic signed [23:0] c,
        input logic               f,
        input logic               t);
        logic signed [23:0] v;
        v = f ? (c * 24'sd9) / 24'sd5 + 24'sd320 : c;
        if (!t) begin
            v = v / 24'sd10;
        end
        return v;
    endfunction

    function automatic logic [15:0] tif_sat(
        input logic signed [23:0] v,
        input logic               uns);
        logic [15:0] w;
        w = v[15:0];
        if (uns) begin
            if (v > 24'sd65535) w = 16'hffff;
            if (v < 24'sd0) w = 16'h0000;
        end else begin
            if (v > 24'sd32767) w = W_OVER;
            if (v < -24'sd32767) w = W_UNDER;
        end
        return w;
    endfunction

    function automatic logic signed [23:0] tif_mrg(
        input logic signed [23:0] l);
        logic signed [23:0] a;
        a = (l < 24'sd0) ? -l : l;
        return (a * PCT_NUM) / PCT_DEN;
    endfunction

    tif_st_t q;
    tif_st_t d;

    // ------------------------------------------------------------
    // sample classification
    // ------------------------------------------------------------
    logic [3:0]         cfg_w;
    logic [31:0]        lim_w;
    logic               fahr_w;
    logic               tenth_w;
    logic               is_mv_w;
    logic               ocd_w;
    logic signed [23:0] c_w;
    logic signed [23:0] hi_w;
    logic signed [23:0] lo_w;
    logic               over_w;
    logic               under_w;
    logic               beyond_w;
    logic               oor_w;
    logic               warn_w;
    logic               uns_w;
    logic signed [23:0] conv_w;
    logic [15:0]        data_w;
    logic [15:0]        cjw_w;

    assign cfg_w   = q.ccfg[i_smp.ch];
    assign lim_w   = q.lim[i_smp.ch];
    assign fahr_w  = q.gcfg[GCFG_FAHR];
    assign tenth_w = q.gcfg[GCFG_TENTH];
    assign is_mv_w = (cfg_w[2:0] == TY_MV);
    assign ocd_w   = is_mv_w ? cfg_w[CCFG_OCD] : 1'b1;
    assign c_w     = 24'(signed'(i_smp.val));
    assign hi_w    = 24'(signed'(lim_w[15:0]));
    assign lo_w    = 24'(signed'(lim_w[31:16]));

    assign beyond_w = !is_mv_w && (c_w > hi_w || c_w < lo_w);
    assign over_w   = !is_mv_w && (c_w > hi_w + tif_mrg(hi_w));
    assign under_w  = !is_mv_w && (c_w < lo_w - tif_mrg(lo_w));

    // broken wire on a thermocouple forces out-of-range
    assign oor_w = is_mv_w ? (ocd_w && (i_smp.open || i_smp.val == W_OPEN))
                           : (i_smp.open || over_w || under_w);
    assign warn_w = beyond_w && !oor_w;

    assign uns_w  = (cfg_w[2:0] == TY_B) && fahr_w && tenth_w;
    assign conv_w = tif_conv(c_w, fahr_w, tenth_w);

    // open thermocouple wire reads as the top value, like an over-range; millivolt words stay raw
    always_comb begin
        data_w = tif_sat(conv_w, uns_w);
        if (is_mv_w) begin
            data_w = i_smp.val;
        end else if (i_smp.open || over_w) begin
            data_w = W_OVER;
        end else if (under_w) begin
            data_w = W_UNDER;
        end
    end

    assign cjw_w = tif_sat(tif_conv(24'(signed'(i_cj.val)), fahr_w, tenth_w), 1'b0);

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic        setup_w;
    logic        wr_w;
    logic [32:0] rd_w;

    assign setup_w = i_psel && !i_penable && !q.pready;
    assign wr_w    = i_psel && i_penable && q.pready && i_pwrite && !q.pslverr;

    always_comb begin
        rd_w = {1'b1, 32'h0000_0000};
        if (i_paddr[1:0] == 2'b00) begin
            if (i_paddr[7:5] == OFS_DATA[7:5]) begin
                rd_w = {1'b0, 16'h0000, q.data[i_paddr[4:2]]};
            end else if (i_paddr[7:5] == OFS_CCFG[7:5]) begin
                rd_w = {1'b0, 28'h000_0000, q.ccfg[i_paddr[4:2]]};
            end else if (i_paddr[7:5] == OFS_LIM[7:5]) begin
                rd_w = {1'b0, q.lim[i_paddr[4:2]]};
            end else if (i_paddr == OFS_FLAG) begin
                rd_w = {1'b0, 16'h0000, q.oor, q.warn};
            end else if (i_paddr == OFS_CJ) begin
                rd_w = {1'b0, 16'h0000, q.cj};
            end else if (i_paddr == OFS_GCFG) begin
                rd_w = {1'b0, 30'h0000_0000, q.gcfg};
            end else if (i_paddr == OFS_IST) begin
                rd_w = {1'b0, 16'h0000, q.ist};
            end else if (i_paddr == OFS_IMSK) begin
                rd_w = {1'b0, 16'h0000, q.imsk};
            end
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [15:0] ev;
        logic [15:0] clr;
        ev  = 16'h0000;
        clr = 16'h0000;
        d   = q;
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        // answer in the access cycle right after setup
        if (setup_w) begin
            d.pready = 1'b1;
            {d.pslverr, d.prdata} = rd_w;
        end
        if (wr_w) begin
            if (i_paddr[7:5] == OFS_CCFG[7:5]) begin
                d.ccfg[i_paddr[4:2]] = i_pwdata[3:0];
            end else if (i_paddr[7:5] == OFS_LIM[7:5]) begin
                d.lim[i_paddr[4:2]] = i_pwdata;
            end else if (i_paddr == OFS_GCFG) begin
                d.gcfg = i_pwdata[1:0];
            end else if (i_paddr == OFS_IST) begin
                clr = i_pwdata[15:0];
            end else if (i_paddr == OFS_IMSK) begin
                d.imsk = i_pwdata[15:0];
            end
        end
        // data and both flags move together
        if (i_smp.vld) begin
            d.data[i_smp.ch] = data_w;
            d.oor[i_smp.ch]  = oor_w;
            d.warn[i_smp.ch] = warn_w;
            ev[{1'b1, i_smp.ch}] = oor_w && !q.oor[i_smp.ch];
            ev[{1'b0, i_smp.ch}] = warn_w && !q.warn[i_smp.ch];
        end
        if (i_cj.vld) begin
            d.cj = cjw_w;
        end
        // set beats a same-cycle clear
        d.ist = (q.ist & ~clr) | ev;
        d.irq = |(d.ist & d.imsk);
        if (!i_resetn) begin
            d.data    = '0;
            d.warn    = 8'h00;
            d.oor     = 8'h00;
            d.cj      = 16'h0000;
            d.gcfg    = RST_GCFG;
            d.ccfg    = {8{RST_CCFG}};
            d.lim     = {8{RST_LIM}};
            d.ist     = 16'h0000;
            d.imsk    = 16'h0000;
            d.prdata  = 32'h0000_0000;
            d.pready  = 1'b0;
            d.pslverr = 1'b0;
            d.irq     = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        q <= d;
    end

    assign o_prdata  = q.prdata;
    assign o_pready  = q.pready;
    assign o_pslverr = q.pslverr;
    assign o_irq     = q.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);

    logic tc_ok_w;
    assign tc_ok_w = i_smp.vld && !is_mv_w && !i_smp.open;

    property p_words;
        setup_w && i_paddr == OFS_FLAG
            |=> o_pready && o_prdata == {16'h0000, $past(q.oor), $past(q.warn)};
    endproperty
    a_words: assert property (p_words) else $error("flag word read wrong");

    property p_warn;
        tc_ok_w && c_w > hi_w && !oor_w |=> q.warn[$past(i_smp.ch)];
    endproperty
    a_warn: assert property (p_warn) else $error("warning not raised");

    property p_oor;
        tc_ok_w && over_w |=> q.oor[$past(i_smp.ch)] && !q.warn[$past(i_smp.ch)];
    endproperty
    a_oor: assert property (p_oor) else $error("out-of-range not set");

    property p_excl;
        (q.warn & q.oor) == 8'h00;
    endproperty
    a_excl: assert property (p_excl) else $error("warning with out-of-range");

    property p_tenth;
        tc_ok_w && !fahr_w && tenth_w && !over_w && !under_w
            |=> q.data[$past(i_smp.ch)] == $past(i_smp.val);
    endproperty
    a_tenth: assert property (p_tenth) else $error("tenth C not passed");

    property p_cj;
        i_cj.vld && i_cj.val == 16'h0000 && fahr_w && tenth_w
            ##1 !i_cj.vld |=> q.cj == 16'h0140;
    endproperty
    a_cj: assert property (p_cj) else $error("cold junction units wrong");

    property p_open;
        i_smp.vld && !is_mv_w && i_smp.open
            |=> q.oor[$past(i_smp.ch)] && !q.warn[$past(i_smp.ch)]
                && q.data[$past(i_smp.ch)] == W_OVER;
    endproperty
    a_open: assert property (p_open) else $error("open wire handling");

    property p_under;
        tc_ok_w && under_w |=> q.data[$past(i_smp.ch)] == W_UNDER;
    endproperty
    a_under: assert property (p_under) else $error("under-range word");

    property p_mvoff;
        i_smp.vld && is_mv_w && !cfg_w[CCFG_OCD] |=> !q.oor[$past(i_smp.ch)];
    endproperty
    a_mvoff: assert property (p_mvoff) else $error("detect not disabled");

    property p_mvff;
        i_smp.vld && is_mv_w && cfg_w[CCFG_OCD] && i_smp.val == W_OPEN
            |=> q.oor[$past(i_smp.ch)];
    endproperty
    a_mvff: assert property (p_mvff) else $error("mV full scale missed");

    property p_uns;
        tc_ok_w && uns_w && !over_w && !under_w
            && conv_w > 24'sd32767 && conv_w < 24'sd65536
            |=> q.data[$past(i_smp.ch)] == $past(conv_w[15:0]);
    endproperty
    a_uns: assert property (p_uns) else $error("type B unsigned wrong");

    property p_over;
        tc_ok_w && over_w |=> q.data[$past(i_smp.ch)] == W_OVER;
    endproperty
    a_over: assert property (p_over) else $error("over-range word");

    // signed reading beyond 16 bits after conversion clips, never wraps
    property p_sat;
        tc_ok_w && !uns_w && !over_w && !under_w && conv_w > 24'sd32767
            |=> q.data[$past(i_smp.ch)] == W_OVER;
    endproperty
    a_sat: assert property (p_sat) else $error("signed word not clipped");

    property p_mvword;
        i_smp.vld && is_mv_w
            |=> q.data[$past(i_smp.ch)] == $past(i_smp.val);
    endproperty
    a_mvword: assert property (p_mvword) else $error("mV word not raw");

    // a new flag always reaches status, even against a same-cycle clear
    property p_evoor;
        i_smp.vld && oor_w && !q.oor[i_smp.ch]
            |=> q.ist[{1'b1, $past(i_smp.ch)}];
    endproperty
    a_evoor: assert property (p_evoor) else $error("out-of-range event lost");

    property p_evwarn;
        i_smp.vld && warn_w && !q.warn[i_smp.ch]
            |=> q.ist[{1'b0, $past(i_smp.ch)}];
    endproperty
    a_evwarn: assert property (p_evwarn) else $error("warning event lost");

    // ------------------------------------------------------------
    // bus checks
    // ------------------------------------------------------------
    // zero wait states: one answer cycle per transfer
    property p_pulse;
        o_pready |=> !o_pready;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");

    // refused access answers at once with zero data
    property p_misal;
        setup_w && i_paddr[1:0] != 2'b00
            |=> o_pready && o_pslverr && o_prdata == 32'h0000_0000;
    endproperty
    a_misal: assert property (p_misal) else $error("misaligned access accepted");

    // reading words belong to the samples, the bus cannot touch them
    property p_ro;
        wr_w && i_paddr[7:5] == OFS_DATA[7:5] && !i_smp.vld
            |=> q.data == $past(q.data);
    endproperty
    a_ro: assert property (p_ro) else $error("reading word written by bus");

    property p_gcfg;
        wr_w && i_paddr == OFS_GCFG
            |=> q.gcfg == $past(i_pwdata[1:0]);
    endproperty
    a_gcfg: assert property (p_gcfg) else $error("unit setting not taken");

    c_over: cover property (tc_ok_w && over_w);
    c_open: cover property (i_smp.vld && i_smp.open ##1 o_irq);
    c_uns:  cover property (tc_ok_w && uns_w && conv_w > 24'sd32767);
    c_rd:   cover property (setup_w ##1 o_pready ##1 setup_w);

endmodule

// ==== tb/tif_front_model.sv ====
// Purpose: sensor front end feeding channel and cold junction samples
// Assumes: one clock, each sample valid for one cycle
// Notes:   idle lines carry the inverse of the last value, never a copy
`timescale 1ns/1ps
module tif_front_model
    import tif_pkg::*;
(
    input  wire logic i_clk_sys,
    output tif_smp_t  o_smp,
    output tif_cj_t   o_cj
);
    initial begin
        o_smp = '0;
        o_cj = '0;
    end
    task automatic send(input logic [2:0] ch, input logic op, input logic [15:0] v);
        @(posedge i_clk_sys);
        o_smp <= '{vld: 1'b1, ch: ch, open: op, val: v};
        @(posedge i_clk_sys);
        o_smp <= '{vld: 1'b0, ch: ~ch, open: ~op, val: ~v};
    endtask
    task automatic send_cj(input logic [15:0] v);
        @(posedge i_clk_sys);
        o_cj <= '{vld: 1'b1, val: v};
        @(posedge i_clk_sys);
        o_cj <= '{vld: 1'b0, val: ~v};
    endtask
endmodule

// ==== tb/tif_formatter_tb.sv ====
// Purpose: self-checking bench of the thermocouple word formatter
// Assumes: APB slave answers on its own, samples taken on valid edge
// Notes:   expectations rebuilt from limits and unit settings
`timescale 1ns/1ps
module tif_formatter_tb
    import tif_pkg::*;
;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic [31:0] r;
    logic        pready;
    logic        pslverr;
    logic        err;
    logic        irq;
    logic [7:0]  ew = 8'h00;
    logic [7:0]  eo = 8'h00;
    logic [1:0]  g = 2'h2;
    tif_smp_t    smp;
    tif_cj_t     cj;
    int          n_fail = 0;
    int          check_count = 0;
    int          seed = 32'h0ada_faed;
    int          i;
    int          cn[8] = '{1000, 1001, 1024, 1025, -501, -512, -513, -500};

    always #12.5 clk = ~clk;

    tif_front_model fm_u (.i_clk_sys(clk), .o_smp(smp), .o_cj(cj));
    tif_formatter dut_u (
        .i_clk_sys(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_smp(smp),
        .i_cj(cj), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_irq(irq)
    );
    // ----
    // tasks
    // ----
    task automatic end_sim();
        if (n_fail == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        check_count++;
        if (s !== e) begin
            n_fail++;
            $display("mismatch %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            end_sim();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdw(input logic [7:0] a);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // tenths of C to selected units; 1-degree truncates toward zero
    function automatic logic [15:0] conv(input int c, input logic f, input logic t,
                                         input logic u);
        int v;
        v = f ? c * 9 / 5 + 320 : c;
        if (!t) v = v / 10;
        if (u) return (v < 0) ? 16'h0000 : (v > 65535) ? 16'hffff : 16'(v);
        return (v < -32767) ? 16'h8001 : (v > 32767) ? 16'h7fff : 16'(v);
    endfunction
    function automatic logic [15:0] tc_exp(input int ch, input logic op, input int v,
                                           input int hi, input int lo, input logic b);
        int hm;
        int lm;
        hm = hi + (hi < 0 ? -hi : hi) * 24 / 1000;
        lm = lo - (lo < 0 ? -lo : lo) * 24 / 1000;
        eo[ch] = op || v > hm || v < lm;
        ew[ch] = !eo[ch] && (v > hi || v < lo);
        if (op || v > hm) return W_OVER;
        if (v < lm) return W_UNDER;
        return conv(v, g[0], g[1], b && g == 2'h3);
    endfunction
    task automatic ch_chk(input int ch, input logic [15:0] e);
        rdw(OFS_DATA + 8'(4 * ch));
        chk("word", {16'h0000, e}, rd);
        rdw(OFS_FLAG);
        chk("flags", {16'h0000, eo, ew}, rd);
    endtask
    task automatic tc_run(input int ch, input logic [3:0] cf, input logic op,
                          input int v, input int hi, input int lo);
        wr(OFS_CCFG + 8'(4 * ch), {28'h0, cf});
        wr(OFS_LIM + 8'(4 * ch), {16'(lo), 16'(hi)});
        fm_u.send(3'(ch), op, 16'(v));
        ch_chk(ch, tc_exp(ch, op, v, hi, lo, cf[2:0] == TY_B));
    endtask
    task automatic mv_run(input int ch, input logic oc, input logic op,
                          input logic [15:0] v);
        wr(OFS_CCFG + 8'(4 * ch), {28'h0, oc, TY_MV});
        fm_u.send(3'(ch), op, v);
        eo[ch] = oc & (op | v == 16'hffff);
        ew[ch] = 1'b0;
        ch_chk(ch, v);
    endtask
    // ----
    // sequence
    // ----
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        rdw(OFS_GCFG);
        chk("gcfg", {30'h0, RST_GCFG}, rd);
        for (i = 0; i < 8; i++) begin
            rdw(OFS_CCFG + 8'(4 * i));
            chk("ccfg", {28'h0, RST_CCFG}, rd);
            rdw(OFS_LIM + 8'(4 * i));
            chk("lim", RST_LIM, rd);
        end
        rdw(8'h34);
        chk("err", 32'h0000_0001, {31'h0, err});
        rdw(8'h21);
        chk("err", 32'h0000_0001, {31'h0, err});
        chk("rd", 32'h0000_0000, rd);
        wr(OFS_DATA, 32'h0000_1234);
        rdw(OFS_DATA);
        chk("word", 32'h0000_0000, rd);
        for (i = 0; i < 8; i++) tc_run(3, 4'h1, 1'b0, cn[i], 1000, -500);
        tc_run(2, 4'h2, 1'b0, 1010, 1000, -500);
        tc_run(2, 4'h2, 1'b1, 1010, 1000, -500);
        tc_run(4, 4'h6, 1'b1, 0, 1000, -500);
        mv_run(6, 1'b1, 1'b0, 16'hffff);
        mv_run(6, 1'b1, 1'b1, 16'h8000);
        mv_run(6, 1'b0, 1'b1, 16'hffff);
        for (i = 0; i < 4; i++) begin
            g = 2'(i);
            wr(OFS_GCFG, {30'h0, g});
            tc_run(0, 4'h1, 1'b0, -1234, 30000, -3000);
            tc_run(0, 4'h1, 1'b0, 20000, 30000, -3000);
            tc_run(1, {1'b1, TY_B}, 1'b0, 18200, 18500, 130);
            fm_u.send_cj(16'h0000);
            fm_u.send_cj(16'hffc7);
            rdw(OFS_CJ);
            chk("cj", {16'h0000, conv(-57, g[0], g[1], 1'b0)}, rd);
        end
        tc_run(5, 4'h1, 1'b0, 0, 1000, -500);
        wr(OFS_IST, 32'h0000_ffff);
        wr(OFS_IMSK, 32'h0000_2000);
        tc_run(5, 4'h1, 1'b1, 0, 1000, -500);
        rdw(OFS_IST);
        chk("ist", 32'h0000_2000, rd);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        wr(OFS_IMSK, 32'h0000_0000);
        rdw(OFS_IST);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        wr(OFS_IMSK, 32'h0000_2000);
        wr(OFS_IST, 32'h0000_2000);
        rdw(OFS_IST);
        chk("ist", 32'h0000_0000, rd);
        chk("irq", 32'h0000_0000, {31'h0, irq});
        // random mix of units, types and values around the limits
        for (i = 0; i < 40; i++) begin
            r = $random(seed);
            g = r[1:0];
            wr(OFS_GCFG, {30'h0, g});
            if (r[12]) begin
                mv_run(int'(r[4:2]), r[13], r[14], r[15] ? 16'hffff : r[31:16]);
            end else begin
                tc_run(int'(r[4:2]), {r[13], 3'(r[7:5] % 3'h7 + 3'h1)}, r[8] & r[9],
                       $signed(r[31:16]) % 1200, 1000, -800);
            end
        end
        end_sim();
    end
endmodule
